// *** rtl/outport_map.svh ***
// register indices, field positions and reset values of the output port block
// assumes inclusion by the serializer and by every module that decodes registers
`ifndef OUTPORT_MAP_SVH
`define OUTPORT_MAP_SVH
// register indices on the register port
`define REG_PORT_SEL     4'h0
`define REG_CLK_STRM     4'h1
`define REG_SAMPLE_BASE  4'h2
`define REG_SAMPLE_LAST  4'h9
`define REG_STREAM_CNT   4'ha
// reset values
`define PORT_SEL_RESET   24'h000000
`define CLK_STRM_RESET   10'h000
// writable bits of the clock and stream register, reserved 6:4 kept zero
`define CLK_STRM_WMASK   10'h38f
// per-port byte of the channel select register
`define PORT_FIELD_W     8
`define EN_LSB           0
`define FMT_OFS          6
`define APP_OFS          7
// clock and stream register fields
`define DIV_MSB          9
`define DIV_LSB          8
`define MASTER_BIT       7
`define STRM_MSB         3
// stream code range with explicit grouping
`define STRM_CODE_LAST   4'h9
`endif

// *** rtl/outport_pkg.sv ***
// types shared by the output port block
// assumes outport_map.svh holds the numeric constants
package outport_pkg;
   typedef logic [15:0] sample_t;
   typedef logic [11:0] rssi_t;
   typedef logic [2:0]  chan_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_OVHD = 2'b01,
      ST_SEND = 2'b10
   } port_state_e;
   typedef enum logic [1:0] {
      W_FIRST  = 2'b00,
      W_SECOND = 2'b01,
      W_GAIN   = 2'b10
   } word_e;
endpackage

// *** rtl/port_link_if.sv ***
// per-port settings and sample feed from the register block to one serializer
// assumes one instance per output port, driven from the top module
`timescale 1ns/1ps
interface port_link_if;
   logic                        tick;
   logic [5:0]                  en;
   logic                        fmt_par;
   logic                        append;
   outport_pkg::sample_t [5:0]  s_i;
   outport_pkg::sample_t [5:0]  s_q;
   outport_pkg::rssi_t [5:0]    rssi;
   logic [5:0]                  s_new;
   logic [5:0]                  r_new;
   outport_pkg::chan_t [5:0]    strm;
   modport src (output tick, en, fmt_par, append, s_i, s_q, rssi, s_new, r_new, strm);
   modport dst (input tick, en, fmt_par, append, s_i, s_q, rssi, s_new, r_new, strm);
endinterface

// *** rtl/outport_serializer.sv ***
// one parallel output port: rounds of overhead tick then channel words
// assumes link.tick is a one-cycle port clock event and ce freezes state
`timescale 1ns/1ps
`include "outport_map.svh"
module outport_serializer (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              ce,
   port_link_if.dst               link,
   output outport_pkg::sample_t   data_ff,
   output logic                   valid_ff,
   output outport_pkg::chan_t     chan_ff,
   output logic                   gain_ff,
   output outport_pkg::chan_t     strm_ff
);
   outport_pkg::port_state_e state_ff;
   outport_pkg::word_e       word_ff;
   logic [5:0]               pend_ff;
   logic [5:0]               fresh_ff;
   logic [5:0]               sel_ff;
   outport_pkg::chan_t       cur;
   logic                     gain_due;
   logic                     last_word;
   logic [5:0]               cur_bit;
   logic [5:0]               sel_left;
   logic [5:0]               ready;
   logic                     step;

   // lowest selected channel is served first
   always_comb begin
      cur = 3'h0;
      for (int i = 5; i >= 0; i--) begin
         if (sel_ff[i]) begin
            cur = 3'(i);
         end
      end
   end

   assign step      = ce & link.tick;
   assign cur_bit   = 6'h01 << cur;
   assign sel_left  = sel_ff & ~cur_bit;
   assign ready     = pend_ff & link.en; // RULE_04
   assign gain_due  = link.append | fresh_ff[cur]; // RULE_01 RULE_02
   assign last_word = (word_ff == outport_pkg::W_GAIN) |
                      (!gain_due & (link.fmt_par ? word_ff == outport_pkg::W_FIRST
                                                 : word_ff == outport_pkg::W_SECOND));

   // round sequencing, one overhead tick before each round
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= outport_pkg::ST_IDLE;
         word_ff  <= outport_pkg::W_FIRST;
         sel_ff   <= 6'h00;
      end else if (step) begin
         unique case (state_ff)
            outport_pkg::ST_IDLE: begin
               if (|ready) begin
                  sel_ff   <= ready;
                  state_ff <= outport_pkg::ST_OVHD; // RULE_16
               end
            end
            outport_pkg::ST_OVHD: begin
               state_ff <= outport_pkg::ST_SEND;
               word_ff  <= outport_pkg::W_FIRST;
            end
            outport_pkg::ST_SEND: begin
               if (last_word) begin
                  word_ff <= outport_pkg::W_FIRST;
                  if (sel_left != 6'h00) begin
                     sel_ff <= sel_left;
                  end else if (|ready) begin
                     sel_ff   <= ready;
                     state_ff <= outport_pkg::ST_OVHD; // RULE_16
                  end else begin
                     sel_ff   <= 6'h00;
                     state_ff <= outport_pkg::ST_IDLE;
                  end
               end else if (word_ff == outport_pkg::W_FIRST && !link.fmt_par) begin
                  word_ff <= outport_pkg::W_SECOND;
               end else begin
                  word_ff <= outport_pkg::W_GAIN;
               end
            end
            default: state_ff <= outport_pkg::ST_IDLE;
         endcase
      end
   end

   // pending samples and fresh gain words, a new event wins over the clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_ff  <= 6'h00;
         fresh_ff <= 6'h00;
      end else if (ce) begin
         pend_ff  <= (pend_ff & ~((step && (state_ff == outport_pkg::ST_IDLE ||
                     (state_ff == outport_pkg::ST_SEND && last_word && sel_left == 6'h00)))
                     ? ready : 6'h00)) | link.s_new;
         fresh_ff <= (fresh_ff & ~((step && state_ff == outport_pkg::ST_SEND &&
                     word_ff == outport_pkg::W_GAIN) ? cur_bit : 6'h00)) | link.r_new; // RULE_02
      end
   end

   // word on the pins, held for one port clock period
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_ff  <= 16'h0000;
         valid_ff <= 1'b0;
         chan_ff  <= 3'h0;
         gain_ff  <= 1'b0;
         strm_ff  <= 3'h0;
      end else if (step) begin
         valid_ff <= (state_ff == outport_pkg::ST_SEND);
         chan_ff  <= cur; // RULE_17
         strm_ff  <= link.strm[cur];
         gain_ff  <= (word_ff == outport_pkg::W_GAIN);
         if (word_ff == outport_pkg::W_GAIN) begin
            data_ff <= {4'h0, link.rssi[cur]};
         end else if (word_ff == outport_pkg::W_SECOND) begin
            data_ff <= link.s_q[cur];
         end else if (link.fmt_par) begin
            data_ff <= {link.s_i[cur][15:8], link.s_q[cur][15:8]}; // RULE_03
         end else begin
            data_ff <= link.s_i[cur]; // RULE_03
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence ovhd_step_s;
      step && state_ff == outport_pkg::ST_OVHD;
   endsequence
   overhead_no_word_a: assert property (ovhd_step_s |=> !valid_ff && state_ff == outport_pkg::ST_SEND) // RULE_16
      else $error("overhead tick produced a word");
   append_gain_a: assert property (step && state_ff == outport_pkg::ST_SEND && link.append &&
         !link.fmt_par && word_ff == outport_pkg::W_SECOND |=> word_ff == outport_pkg::W_GAIN) // RULE_01
      else $error("gain word missing with append set");
   stale_gain_a: assert property (step && state_ff == outport_pkg::ST_SEND && !link.append &&
         !fresh_ff[cur] && word_ff == outport_pkg::W_SECOND |=> word_ff == outport_pkg::W_FIRST) // RULE_02
      else $error("stale gain word sent");
   parallel_word_a: assert property (step && state_ff == outport_pkg::ST_SEND && link.fmt_par &&
         word_ff == outport_pkg::W_FIRST |=> data_ff == {$past(link.s_i[cur][15:8]),
         $past(link.s_q[cur][15:8])}) // RULE_03
      else $error("parallel word wrong");
   enabled_only_a: assert property (step && state_ff == outport_pkg::ST_IDLE && |ready |=>
         (sel_ff & ~$past(link.en)) == 6'h00) // RULE_04
      else $error("disabled channel selected");
endmodule

// *** rtl/outport_block.sv ***
// parallel output port block: settings, sample registers, port clock, three ports
// assumes samples and signal-strength words arrive as one-cycle strobes on SYS_CLK
// Behaviour
// RULE_01: append bit set puts a gain word after every sample on that port.
// RULE_02: append bit clear sends a gain word only after it was refreshed.
// RULE_03: format bit set gives 8-bit parallel I/Q, clear gives 16-bit interleaved.
// RULE_04: bits 21..16 enable channels 5..0 onto port C.
// RULE_05: bits 13..8 enable channels 5..0 onto port B.
// RULE_06: bits 5..0 enable channels 5..0 onto port A.
// RULE_07: master port clock divides core clock by 1, 2, 4 or 8.
// RULE_08: master mode drives the port clock pin and sends data on it.
// RULE_09: slave mode takes the port clock from outside and sends on it.
// RULE_10: master bit is clear after reset, so the clock pin starts as input.
// RULE_11: software writes zero to the three reserved control bits.
// RULE_12: stream codes 0 to 4 merge channel 0 with the next one to five.
// RULE_13: codes 5 to 9 give fixed groupings, any other code six streams.
// RULE_14: channels 0 to 3 expose their latest in-phase sample read-only.
// RULE_15: channels 0 to 3 expose their latest quadrature sample read-only.
// RULE_16: each output round spends one extra overhead port clock tick.
// RULE_17: a channel's words all leave on one single port.
// RULE_18: reading sample registers has no effect on datapath or ports.
`timescale 1ns/1ps
`include "outport_map.svh"
module outport_block (
   input  wire logic                        SYS_CLK,
   input  wire logic                        RSTN,
   input  wire logic                        CE,
   input  wire logic [3:0]                  REG_ADDR,
   input  wire logic                        REG_WR,
   input  wire logic [23:0]                 REG_WDATA,
   input  wire logic                        REG_RD,
   output logic [23:0]                      REG_RDATA,
   input  wire logic [5:0]                  SAMP_VALID,
   input  wire outport_pkg::sample_t [5:0]  SAMP_I,
   input  wire outport_pkg::sample_t [5:0]  SAMP_Q,
   input  wire logic [5:0]                  RSSI_VALID,
   input  wire outport_pkg::rssi_t [5:0]    RSSI_WORD,
   input  wire logic                        PCLK_I,
   output logic                             PCLK_O,
   output logic                             PCLK_OE,
   output outport_pkg::sample_t [2:0]       PORT_DATA,
   output logic [2:0]                       PORT_VALID,
   output outport_pkg::chan_t [2:0]         PORT_CHAN,
   output logic [2:0]                       PORT_GAIN,
   output outport_pkg::chan_t [2:0]         PORT_STREAM
);
   logic [23:0]                port_sel_ff;
   logic [9:0]                 clk_strm_ff;
   outport_pkg::sample_t [5:0] lat_i_ff;
   outport_pkg::sample_t [5:0] lat_q_ff;
   outport_pkg::rssi_t [5:0]   lat_r_ff;
   logic [23:0]                nxt_rdata;
   logic [23:0]                rdata_ff;
   logic [2:0]                 div_cnt_ff;
   logic [2:0]                 div_top;
   logic                       pclk_o_ff;
   logic                       pclk_in_ff;
   logic                       tick_m;
   logic                       tick_s;
   logic                       ptick;
   logic                       master;
   logic [1:0]                 div_code;
   logic [3:0]                 strm_code;
   logic [5:0]                 starts;
   outport_pkg::chan_t [5:0]   strm_id;
   logic [2:0]                 strm_cnt;
   logic [2:0][5:0]            own;
   logic [2:0]                 samp_idx;

   assign master    = clk_strm_ff[`MASTER_BIT];
   assign div_code  = clk_strm_ff[`DIV_MSB:`DIV_LSB];
   assign strm_code = clk_strm_ff[`STRM_MSB:0];

   // settings registers; reserved bits never stored
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         port_sel_ff <= `PORT_SEL_RESET;
         clk_strm_ff <= `CLK_STRM_RESET; // RULE_10
      end else if (CE && REG_WR) begin
         if (REG_ADDR == `REG_PORT_SEL) begin
            port_sel_ff <= REG_WDATA;
         end
         if (REG_ADDR == `REG_CLK_STRM) begin
            clk_strm_ff <= REG_WDATA[9:0] & `CLK_STRM_WMASK; // RULE_11
         end
      end
   end

   // latest datapath samples and signal-strength words, kept per channel
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         lat_i_ff <= '0;
         lat_q_ff <= '0;
         lat_r_ff <= '0;
      end else if (CE) begin
         for (int c = 0; c < 6; c++) begin
            if (SAMP_VALID[c]) begin
               lat_i_ff[c] <= SAMP_I[c]; // RULE_14
               lat_q_ff[c] <= SAMP_Q[c]; // RULE_15
            end
            if (RSSI_VALID[c]) begin
               lat_r_ff[c] <= RSSI_WORD[c];
            end
         end
      end
   end

   // read mux, answer one cycle after the strobe
   assign samp_idx = 3'(REG_ADDR - `REG_SAMPLE_BASE);
   always_comb begin
      nxt_rdata = 24'h000000;
      if (REG_ADDR == `REG_PORT_SEL) begin
         nxt_rdata = port_sel_ff;
      end else if (REG_ADDR == `REG_CLK_STRM) begin
         nxt_rdata = {14'h0000, clk_strm_ff};
      end else if (REG_ADDR >= `REG_SAMPLE_BASE && REG_ADDR <= `REG_SAMPLE_LAST) begin
         nxt_rdata = {8'h00, samp_idx[0] ? lat_q_ff[samp_idx[2:1]]
                                         : lat_i_ff[samp_idx[2:1]]}; // RULE_14 RULE_15
      end else if (REG_ADDR == `REG_STREAM_CNT) begin
         nxt_rdata = {21'h000000, strm_cnt};
      end
   end

   // reads only load the answer register
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_ff <= 24'h000000;
      end else if (CE && REG_RD) begin
         rdata_ff <= nxt_rdata; // RULE_18
      end
   end
   assign REG_RDATA = rdata_ff;

   // master divider: terminal count is divisor minus one
   assign div_top = 3'((4'h1 << div_code) - 4'h1); // RULE_07
   assign tick_m  = (div_cnt_ff >= div_top);
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         div_cnt_ff <= 3'h0;
         pclk_o_ff  <= 1'b0;
      end else if (CE) begin
         div_cnt_ff <= tick_m ? 3'h0 : div_cnt_ff + 3'h1; // RULE_07
         pclk_o_ff  <= (div_top == 3'h0) | tick_m | (div_cnt_ff < (div_top >> 1));
      end
   end

   // slave clock is synchronous; its rising edge marks a port tick
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pclk_in_ff <= 1'b0;
      end else if (CE) begin
         pclk_in_ff <= PCLK_I;
      end
   end
   assign tick_s  = PCLK_I & ~pclk_in_ff; // RULE_09
   assign ptick   = master ? tick_m : tick_s; // RULE_08 RULE_09
   assign PCLK_OE = master; // RULE_08 RULE_10
   assign PCLK_O  = pclk_o_ff & master; // RULE_08

   // stream grouping: a set bit starts a new stream at that channel
   always_comb begin
      unique case (strm_code)
         4'h0:    starts = 6'b111101; // RULE_12
         4'h1:    starts = 6'b111001; // RULE_12
         4'h2:    starts = 6'b110001; // RULE_12
         4'h3:    starts = 6'b100001; // RULE_12
         4'h4:    starts = 6'b000001; // RULE_12
         4'h5:    starts = 6'b001001; // RULE_13
         4'h6:    starts = 6'b010101; // RULE_13
         4'h7:    starts = 6'b110101; // RULE_13
         4'h8:    starts = 6'b101001; // RULE_13
         4'h9:    starts = 6'b010001; // RULE_13
         default: starts = 6'b111111; // RULE_13
      endcase
   end

   // stream index of each channel and the number of streams
   genvar c;
   generate
      for (c = 0; c < 6; c++) begin : g_strm
         always_comb begin
            strm_id[c] = 3'h0;
            for (int k = 1; k <= c; k++) begin
               strm_id[c] = strm_id[c] + 3'(starts[k]);
            end
         end
      end
   endgenerate
   assign strm_cnt = strm_id[5] + 3'h1;

   // channel ownership: port A, then B, then C, never two ports at once
   assign own[0] = port_sel_ff[`EN_LSB +: 6]; // RULE_06
   assign own[1] = port_sel_ff[`PORT_FIELD_W + `EN_LSB +: 6] & ~own[0]; // RULE_05 RULE_17
   assign own[2] = port_sel_ff[2*`PORT_FIELD_W + `EN_LSB +: 6]
                   & ~own[0] & ~own[1]; // RULE_04 RULE_17

   // one serializer per output port
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_port
         port_link_if lnk ();
         assign lnk.tick    = ptick;
         assign lnk.en      = own[p];
         assign lnk.fmt_par = port_sel_ff[p*`PORT_FIELD_W + `FMT_OFS]; // RULE_03
         assign lnk.append  = port_sel_ff[p*`PORT_FIELD_W + `APP_OFS]; // RULE_01
         assign lnk.s_i     = lat_i_ff;
         assign lnk.s_q     = lat_q_ff;
         assign lnk.rssi    = lat_r_ff;
         assign lnk.s_new   = SAMP_VALID;
         assign lnk.r_new   = RSSI_VALID;
         assign lnk.strm    = strm_id;
         outport_serializer u_ser (
            .clk      (SYS_CLK),
            .rstn     (RSTN),
            .ce       (CE),
            .link     (lnk.dst),
            .data_ff  (PORT_DATA[p]),
            .valid_ff (PORT_VALID[p]),
            .chan_ff  (PORT_CHAN[p]),
            .gain_ff  (PORT_GAIN[p]),
            .strm_ff  (PORT_STREAM[p])
         );
      end
   endgenerate

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   pin_drive_a: assert property (PCLK_OE == clk_strm_ff[`MASTER_BIT] && (!PCLK_OE -> !PCLK_O)) // RULE_08
      else $error("port clock pin driven outside master mode");
   div_two_a: assert property (CE && master && div_code == 2'b01 && tick_m ##1 // RULE_07
         CE && div_code == 2'b01 ##1 CE && div_code == 2'b01 |-> tick_m && !$past(tick_m))
      else $error("divide by two period wrong");
   single_port_a: assert property ((own[0] & own[1]) == 6'h00 && (own[2] & (own[0] | own[1]))
         == 6'h00) // RULE_17
      else $error("channel owned by two ports");
   pairs_count_a: assert property (strm_code == 4'h6 |-> strm_cnt == 3'h3 &&
         strm_id[1] == 3'h0 && strm_id[5] == 3'h2) // RULE_13
      else $error("pair grouping wrong");
   merge_count_a: assert property (strm_code == 4'h2 |-> strm_cnt == 3'h3 && strm_id[3] == 3'h0) // RULE_12
      else $error("merged grouping wrong");
   inphase_hold_a: assert property (CE && SAMP_VALID[0] |=> lat_i_ff[0] == $past(SAMP_I[0])) // RULE_14
      else $error("in-phase sample not captured");
   quad_hold_a: assert property (CE && SAMP_VALID[3] |=> lat_q_ff[3] == $past(SAMP_Q[3])) // RULE_15
      else $error("quadrature sample not captured");
   slave_tick_a: assert property (!master && CE && $past(CE) && $rose(PCLK_I) |-> ptick) // RULE_09
      else $error("slave clock edge lost");
endmodule

// *** testbench/outport_sink.sv ***
// downstream receiver model: slave port clock source and word logger
// assumes it shares SYS_CLK with the block and faces its port pins
`timescale 1ns/1ps
module outport_sink (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       run,
   input  wire outport_pkg::sample_t [2:0] data,
   input  wire logic [2:0]                 valid,
   input  wire outport_pkg::chan_t [2:0]   chan,
   input  wire logic [2:0]                 gain,
   input  wire outport_pkg::chan_t [2:0]   strm,
   output logic                            pclk
);
   logic [1:0]  div_ff;
   logic [24:0] q [$];
   // external port clock, stands low while not running
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_ff <= 2'h0;
         pclk   <= 1'b0;
      end else if (run) begin
         div_ff <= div_ff + 2'h1;
         pclk   <= div_ff[0] ? ~pclk : pclk;
      end else begin
         pclk <= 1'b0;
      end
   end
   // log every word shown, tagged with its port
   always @(posedge clk) begin
      for (int p = 0; p < 3; p++) begin
         if (valid[p] === 1'b1) q.push_back({2'(p), gain[p], chan[p], strm[p], data[p]});
      end
   end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the parallel output port block
// assumes outport_sink stands in for the downstream receiver
`timescale 1ns/1ps
module tb_top;
   logic                       SYS_CLK = 1'b0;
   logic                       RSTN = 1'b0;
   logic [3:0]                 REG_ADDR = 4'h0;
   logic                       REG_WR = 1'b0;
   logic [23:0]                REG_WDATA = 24'h0;
   logic                       REG_RD = 1'b0;
   logic [23:0]                REG_RDATA;
   logic [5:0]                 SAMP_VALID = 6'h0;
   outport_pkg::sample_t [5:0] SAMP_I = '0;
   outport_pkg::sample_t [5:0] SAMP_Q = '0;
   logic [5:0]                 RSSI_VALID = 6'h0;
   outport_pkg::rssi_t [5:0]   RSSI_WORD = '0;
   logic                       PCLK_I;
   logic                       PCLK_O;
   logic                       PCLK_OE;
   outport_pkg::sample_t [2:0] PORT_DATA;
   logic [2:0]                 PORT_VALID;
   logic [2:0]                 PORT_GAIN;
   outport_pkg::chan_t [2:0]   PORT_CHAN;
   outport_pkg::chan_t [2:0]   PORT_STREAM;
   logic                       run = 1'b0;
   logic                       pv;
   logic [15:0]                sv = 16'h2c41;
   logic [11:0]                rs [6];
   logic [24:0]                eq [$];
   logic [55:0]                rows [$];
   logic [23:0]                rdv;
   int                         bad_count = 0;
   int                         num_checks = 0;
   int                         n;
   int                         cnt [16] = '{5, 4, 3, 2, 1, 2, 3, 4, 3, 2, 6, 6, 6, 6, 6, 6};
   int                         st [6] = '{0, 0, 1, 2, 3, 4};

   outport_block outport_block_i (
      .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE(1'b1), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
      .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .SAMP_VALID(SAMP_VALID), .SAMP_I(SAMP_I), .SAMP_Q(SAMP_Q), .RSSI_VALID(RSSI_VALID),
      .RSSI_WORD(RSSI_WORD), .PCLK_I(PCLK_I), .PCLK_O(PCLK_O), .PCLK_OE(PCLK_OE),
      .PORT_DATA(PORT_DATA), .PORT_VALID(PORT_VALID), .PORT_CHAN(PORT_CHAN),
      .PORT_GAIN(PORT_GAIN), .PORT_STREAM(PORT_STREAM));

   outport_sink outport_sink_i (
      .clk(SYS_CLK), .rstn(RSTN), .run(run), .data(PORT_DATA), .valid(PORT_VALID),
      .chan(PORT_CHAN), .gain(PORT_GAIN), .strm(PORT_STREAM), .pclk(PCLK_I));

   // core clock, 100 ns period
   always #50 SYS_CLK = ~SYS_CLK;

   // compare and count
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // print counts and verdict, end the run
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // register write and read cycles
   task wr(input logic [3:0] a, input logic [23:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 rdv = REG_RDATA;
   endtask

   // one new sample on a channel, optional gain word refresh
   task pulse(input int ch, input logic rv);
      sv = sv + 16'h1357;
      if (rv) rs[ch] = sv[11:0];
      @(posedge SYS_CLK);
      SAMP_VALID[ch] <= 1'b1;
      SAMP_I[ch] <= sv;
      SAMP_Q[ch] <= ~sv;
      RSSI_VALID[ch] <= rv;
      RSSI_WORD[ch] <= sv[11:0];
      @(posedge SYS_CLK);
      SAMP_VALID <= 6'h0;
      RSSI_VALID <= 6'h0;
   endtask

   function automatic logic [24:0] wd(input int p, input logic g, input int ch,
                                      input logic [15:0] d);
      return {2'(p), g, 3'(ch), 3'(st[ch]), d};
   endfunction

   // send one sample, read it back meanwhile on channels 0 to 3, compare the logged words
   task run_case(input int p, input int ch, input logic rv, input logic par, input logic g);
      outport_sink_i.q.delete();
      eq.delete();
      pulse(ch, rv);
      if (ch < 4) begin
         rd(4'(2 + 2 * ch));
         chk("sample_i", rdv, {8'h0, sv});
         rd(4'(3 + 2 * ch));
         chk("sample_q", rdv, {8'h0, ~sv});
      end
      repeat (8) @(posedge SYS_CLK);
      if (p < 3) begin
         if (par) eq.push_back(wd(p, 1'b0, ch, {sv[15:8], ~sv[15:8]}));
         else eq.push_back(wd(p, 1'b0, ch, sv));
         if (!par) eq.push_back(wd(p, 1'b0, ch, ~sv));
         if (g) eq.push_back(wd(p, 1'b1, ch, {4'h0, rs[ch]}));
      end
      chk("word_count", outport_sink_i.q.size(), eq.size());
      foreach (eq[k]) if (k < outport_sink_i.q.size()) chk("port_word", outport_sink_i.q[k], eq[k]);
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      bad_count++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      rd(4'h1);
      chk("ctrl_reset", rdv, 24'h0);
      chk("pclk_oe_reset", PCLK_OE, 1'b0);
      rows = '{{4'h0, 24'hc3a5f0, 4'h0, 24'hc3a5f0}, {4'h1, 24'h00038f, 4'h1, 24'h00038f},
               {4'h2, 24'h00ffff, 4'h2, 24'h000000}, {4'hb, 24'h000123, 4'hb, 24'h000000}};
      for (int c = 0; c < 16; c++) rows.push_back({4'h1, 20'h0, 4'(c), 4'ha, 21'h0, 3'(cnt[c])});
      foreach (rows[k]) begin
         wr(rows[k][55:52], rows[k][51:28]);
         rd(rows[k][27:24]);
         chk("reg_row", rdv, rows[k][23:0]);
      end
      wr(4'h1, 24'h000080);
      wr(4'h0, 24'h000081);
      run_case(0, 0, 1'b1, 1'b0, 1'b1);
      run_case(0, 0, 1'b0, 1'b0, 1'b1);
      wr(4'h0, 24'h000001);
      run_case(0, 0, 1'b0, 1'b0, 1'b0);
      run_case(0, 0, 1'b1, 1'b0, 1'b1);
      run_case(0, 0, 1'b0, 1'b0, 1'b0);
      wr(4'h0, 24'h004200);
      run_case(1, 1, 1'b1, 1'b1, 1'b1);
      wr(4'h0, 24'h040004);
      run_case(0, 2, 1'b0, 1'b0, 1'b0);
      wr(4'h0, 24'h280000);
      run_case(2, 3, 1'b0, 1'b0, 1'b0);
      run_case(2, 5, 1'b0, 1'b0, 1'b0);
      run_case(3, 4, 1'b0, 1'b0, 1'b0);
      wr(4'h0, 24'h000001);
      @(posedge SYS_CLK);
      SAMP_VALID <= 6'h01;
      repeat (10) @(posedge SYS_CLK);
      n = 0;
      repeat (30) begin
         @(negedge SYS_CLK);
         n += PORT_VALID[0];
      end
      @(posedge SYS_CLK);
      SAMP_VALID <= 6'h0;
      chk("round_len", n, 20);
      for (int d = 0; d < 4; d++) begin
         wr(4'h1, 24'(10'h080 | (d << 8)));
         repeat (4) @(negedge SYS_CLK);
         pv = PCLK_O;
         n = 0;
         repeat (64) begin
            @(negedge SYS_CLK);
            n += (PCLK_O && !pv);
            pv = PCLK_O;
         end
         chk("pclk_rises", n, d ? 64 >> d : 0);
         chk("pclk_oe", PCLK_OE, 1'b1);
      end
      wr(4'h1, 24'h000000);
      pulse(0, 1'b0);
      repeat (20) @(posedge SYS_CLK);
      chk("slave_idle", PORT_DATA[0] === sv, 1'b0);
      chk("slave_oe", PCLK_OE, 1'b0);
      @(posedge SYS_CLK);
      run <= 1'b1;
      n = 0;
      while (n < 60 && PORT_VALID[0] !== 1'b1) begin
         @(negedge SYS_CLK);
         n++;
      end
      chk("slave_word", n < 60, 1'b1);
      chk("slave_data", PORT_DATA[0], sv);
      tally_and_finish();
   end
endmodule
